// ===== scb_host_model.sv
`timescale 1ns/1ns
module scb_host_model (
  input  wire logic       ref_clk_i,
  input  wire logic       sda_i,
  output logic            scl_oe_o,
  output logic            sda_oe_o,
  output logic            res_valid_o,
  output logic            res_is_ack_o,
  output logic      [7:0] res_data_o
);
  // quarter scl period in clocks; 16 keeps the bus just under 400 khz, larger is a slow host
  int q = 16;

  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    res_valid_o = 1'b0;
    res_is_ack_o = 1'b0;
    res_data_o = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // also serves as repeated start: entered with scl low or idle
  task automatic start_cond();
    sda_oe_o = 1'b0;
    tick(q);
    scl_oe_o = 1'b0;
    tick(q);
    sda_oe_o = 1'b1;
    tick(q);
    scl_oe_o = 1'b1;
    tick(q);
  endtask

  task automatic stop_cond();
    sda_oe_o = 1'b1;
    tick(q);
    scl_oe_o = 1'b0;
    tick(q);
    sda_oe_o = 1'b0;
    tick(q);
  endtask

  // data changes only while scl is low, sampled in mid high phase
  task automatic clk_bit(input logic b, output logic s);
    sda_oe_o = ~b;
    tick(q);
    scl_oe_o = 1'b0;
    tick(q);
    s = sda_i;
    tick(q);
    scl_oe_o = 1'b1;
    tick(q);
  endtask

  task automatic report(input logic is_ack, input logic [7:0] d);
    res_is_ack_o = is_ack;
    res_data_o = d;
    res_valid_o = 1'b1;
    tick(1);
    res_valid_o = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    report(1'b1, {7'h00, ~s});
  endtask

  task automatic recv_byte(input logic more);
    logic [7:0] d;
    logic       s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(~more, s);
    report(1'b0, d);
  endtask
endmodule // scb_host_model

// ===== scb_pkg.sv
package scb_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS   = 40;
  localparam int SOFT_RST_NS     = 200;
  localparam int SOFT_RST_CYCLES = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SOFT_RST_LOAD = 3'(SOFT_RST_CYCLES);
  localparam logic [1:0] STRAP_SETTLE  = 2'h3;

  // register offsets
  localparam logic [7:0] ADDR_REG_OFS = 8'h00;
  localparam logic [7:0] RST_REG_OFS  = 8'h01;

  // reset values
  localparam logic [7:0] ADDR_REG_RESET = 8'h00;
  localparam logic [7:0] RST_REG_RESET  = 8'h00;
  localparam logic [7:0] PTR_RESET      = 8'h00;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // field positions
  localparam int OVERRIDE_BIT  = 0;
  localparam int AUTO_PD_BIT   = 7;
  localparam int FULL_RST_BIT  = 1;
  localparam int LOGIC_RST_BIT = 0;

  // strap levels in ascending divider ratio
  localparam int STRAP_LEVELS = 9;
  localparam logic [6:0] STRAP_ADDR [0:STRAP_LEVELS-1] = '{
    7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h13, 7'h14, 7'h15, 7'h1b
  };
  localparam logic [6:0] STRAP_ADDR_RESET = 7'h0c;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_BYTE,
    ST_WR_ACK,
    ST_RD_BYTE,
    ST_RD_ACK
  } scb_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } scb_pins_t;

  typedef struct packed {
    logic      link_up;
    scb_pins_t pins;
    logic [7:0] strap;
  } scb_async_t;

endpackage

// ===== scb_serial_control_bus_slave.sv
// Summary of operation
// [R1] target address picked from nine divider levels sensed on the strap pin
// [R2] nine levels map ascending to addresses 0x0c through 0x1b
// [R3] clock and data pins are only pulled low or released
// [R4] stop is data rising with clock high; start opens a transfer
// [R5] transfers open with start or repeated start, close with stop
// [R6] matching address is acknowledged low; other addresses are left released
// [R7] each written data byte is acknowledged
// [R8] master acks read bytes for more, nacks the last then stops
// [R9] address register bits 7:1 replace strap address when bit 0 set
// [R10] offset 0x01 bit 7 enables power-down while no link is detected
// [R11] offset 0x01 bit 1 resets logic and registers, self clearing
// [R12] offset 0x01 bit 0 resets logic keeping registers, self clearing
// [R13] register pointer advances after every data byte except a master-nacked read byte
`timescale 1ns/1ns
module scb_serial_control_bus_slave (
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [7:0] address_strap_pin_i,
  input  wire logic       link_detected_i,
  output logic            scl_o,
  output logic            scl_oe_o,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            power_down_o,
  output logic            logic_reset_o
);

  scb_pkg::scb_async_t async_in;
  scb_pkg::scb_async_t in_s;
  logic [10:0]         sync_q;
  scb_pkg::scb_pins_t  pins_q;
  logic [3:0]          strap_level;
  logic [6:0]          strap_addr_now;
  logic [6:0]          strap_addr;
  logic [1:0]          settle_cnt;
  logic                strap_taken;

  scb_pkg::scb_state_t state;
  scb_pkg::scb_state_t next_state;
  logic [3:0]          cnt;
  logic [3:0]          next_cnt;
  logic [7:0]          rx;
  logic [7:0]          next_rx;
  logic [7:0]          tx;
  logic [7:0]          next_tx;
  logic [7:0]          ptr;
  logic [7:0]          next_ptr;
  logic                rw;
  logic                next_rw;
  logic                first_byte;
  logic                next_first;
  logic                sda_low;
  logic                next_sda_low;

  logic [7:0]          addr_reg;
  logic                auto_pd_en;
  logic [2:0]          rst_cnt;
  logic [2:0]          next_rst_cnt;

  assign async_in.link_up  = link_detected_i;
  assign async_in.pins.scl = scl_i;
  assign async_in.pins.sda = sda_i;
  assign async_in.strap    = address_strap_pin_i;
  assign in_s              = scb_pkg::scb_async_t'(sync_q);

  scb_sync #(
    .WIDTH (11)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .d_i       (async_in),
    .q_o       (sync_q)
  );

  scb_strap_decode u_strap (
    .level_i (in_s.strap),
    .level_o (strap_level),
    .addr_o  (strap_addr_now)
  );

  // bus condition decode on synchronised pins
  wire scl_rise  = in_s.pins.scl & ~pins_q.scl;
  wire scl_fall  = ~in_s.pins.scl & pins_q.scl;
  wire scl_high  = in_s.pins.scl & pins_q.scl;
  wire start_det = scl_high & pins_q.sda & ~in_s.pins.sda;   // R5
  wire stop_det  = scl_high & ~pins_q.sda & in_s.pins.sda;   // R4
  wire byte_done = (cnt == scb_pkg::BITS_PER_BYTE);

  // register override wins over the strap
  wire       override = addr_reg[scb_pkg::OVERRIDE_BIT];
  wire [6:0] own_addr = override ? addr_reg[7:1] : strap_addr;   // R9
  wire       addr_match = (rx[7:1] == own_addr);                // R6

  wire [7:0] ptr_next_byte = ptr + 8'h01;
  wire       wr_strobe = scl_fall & (state == scb_pkg::ST_WR_BYTE) & byte_done & ~first_byte;
  wire       wr_rst    = wr_strobe & (ptr == scb_pkg::RST_REG_OFS);
  wire       full_rst  = wr_rst & rx[scb_pkg::FULL_RST_BIT];    // R11
  wire       logic_rst = wr_rst & rx[scb_pkg::LOGIC_RST_BIT];   // R12

  // reset bits are self clearing, so they always read back as zero
  function automatic logic [7:0] reg_read(input logic [7:0] ofs, input logic [7:0] a,
                                          input logic pd);
    if (ofs == scb_pkg::ADDR_REG_OFS) begin
      return a;
    end else if (ofs == scb_pkg::RST_REG_OFS) begin
      return {pd, 7'h00};
    end else begin
      return scb_pkg::UNMAPPED_READ;
    end
  endfunction

  wire [7:0] rd_first = reg_read(ptr, addr_reg, auto_pd_en);
  wire [7:0] rd_next  = reg_read(ptr_next_byte, addr_reg, auto_pd_en);

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_rx      = rx;
    next_tx      = tx;
    next_ptr     = ptr;
    next_rw      = rw;
    next_first   = first_byte;
    next_sda_low = sda_low;
    if (start_det) begin
      next_state   = scb_pkg::ST_ADDR;                          // R5
      next_cnt     = 4'h0;
      next_sda_low = 1'b0;
    end else if (stop_det) begin
      next_state   = scb_pkg::ST_IDLE;                          // R4
      next_sda_low = 1'b0;
    end else if (scl_rise) begin
      if (state == scb_pkg::ST_ADDR || state == scb_pkg::ST_WR_BYTE) begin
        next_rx  = {rx[6:0], in_s.pins.sda};
        next_cnt = cnt + 4'h1;
      end else if (state == scb_pkg::ST_RD_BYTE) begin
        next_cnt = cnt + 4'h1;
      end else if (state == scb_pkg::ST_RD_ACK && in_s.pins.sda) begin
        next_state = scb_pkg::ST_IDLE;                          // R8
      end
    end else if (scl_fall) begin
      case (state)
        scb_pkg::ST_ADDR: begin
          if (byte_done) begin
            if (addr_match) begin
              next_state   = scb_pkg::ST_ADDR_ACK;
              next_sda_low = 1'b1;                              // R6
              next_rw      = rx[0];
            end else begin
              next_state   = scb_pkg::ST_IDLE;                  // R6
            end
          end
        end
        scb_pkg::ST_ADDR_ACK: begin
          next_cnt   = 4'h0;
          next_first = 1'b1;
          if (rw) begin
            next_state   = scb_pkg::ST_RD_BYTE;
            next_tx      = rd_first;
            next_sda_low = ~rd_first[7];
          end else begin
            next_state   = scb_pkg::ST_WR_BYTE;
            next_sda_low = 1'b0;
          end
        end
        scb_pkg::ST_WR_BYTE: begin
          if (byte_done) begin
            next_state   = scb_pkg::ST_WR_ACK;
            next_sda_low = 1'b1;                                // R7
            next_first   = 1'b0;
            next_ptr     = first_byte ? rx : ptr_next_byte;     // R13
          end
        end
        scb_pkg::ST_WR_ACK: begin
          next_state   = scb_pkg::ST_WR_BYTE;
          next_sda_low = 1'b0;
          next_cnt     = 4'h0;
        end
        scb_pkg::ST_RD_BYTE: begin
          if (byte_done) begin
            next_state   = scb_pkg::ST_RD_ACK;
            next_sda_low = 1'b0;
          end else begin
            next_tx      = {tx[6:0], 1'b0};
            next_sda_low = ~tx[6];                              // R3
          end
        end
        scb_pkg::ST_RD_ACK: begin
          // only reached after a master ack; a nack already left for idle
          next_state   = scb_pkg::ST_RD_BYTE;                   // R8
          next_cnt     = 4'h0;
          next_ptr     = ptr_next_byte;                         // R13
          next_tx      = rd_next;
          next_sda_low = ~rd_next[7];
        end
        default: begin
          next_state = scb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state      <= scb_pkg::ST_IDLE;
      cnt        <= 4'h0;
      rx         <= 8'h00;
      tx         <= 8'h00;
      ptr        <= scb_pkg::PTR_RESET;
      rw         <= 1'b0;
      first_byte <= 1'b0;
      sda_low    <= 1'b0;
      pins_q     <= '0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      rx         <= next_rx;
      tx         <= next_tx;
      ptr        <= next_ptr;
      rw         <= next_rw;
      first_byte <= next_first;
      sda_low    <= next_sda_low;
      pins_q     <= in_s.pins;
    end
  end

  // strap caught once, after the synchroniser has settled past reset release
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      settle_cnt  <= 2'h0;
      strap_taken <= 1'b0;
      strap_addr  <= scb_pkg::STRAP_ADDR_RESET;
    end else if (!strap_taken) begin
      settle_cnt <= settle_cnt + 2'h1;
      if (settle_cnt == scb_pkg::STRAP_SETTLE) begin
        strap_taken <= 1'b1;
        strap_addr  <= strap_addr_now;                          // R1
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_reg   <= scb_pkg::ADDR_REG_RESET;
      auto_pd_en <= scb_pkg::RST_REG_RESET[scb_pkg::AUTO_PD_BIT];
    end else if (full_rst) begin
      addr_reg   <= scb_pkg::ADDR_REG_RESET;                    // R11
      auto_pd_en <= scb_pkg::RST_REG_RESET[scb_pkg::AUTO_PD_BIT];
    end else if (wr_strobe && ptr == scb_pkg::ADDR_REG_OFS) begin
      addr_reg <= rx;                                           // R9
    end else if (wr_rst) begin
      auto_pd_en <= rx[scb_pkg::AUTO_PD_BIT];                   // R10
    end
  end

  // the bus engine itself is kept out of the soft reset so the ack of that write completes
  assign next_rst_cnt = (full_rst || logic_rst) ? scb_pkg::SOFT_RST_LOAD :
                        (rst_cnt != 3'h0) ? rst_cnt - 3'h1 : 3'h0;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_cnt       <= 3'h0;
      logic_reset_o <= 1'b0;
      power_down_o  <= 1'b0;
      sda_oe_o      <= 1'b0;
      sda_o         <= 1'b0;
      scl_oe_o      <= 1'b0;
      scl_o         <= 1'b0;
    end else begin
      rst_cnt       <= next_rst_cnt;
      logic_reset_o <= (next_rst_cnt != 3'h0);                  // R12
      power_down_o  <= auto_pd_en & ~in_s.link_up;              // R10
      sda_oe_o      <= next_sda_low;                            // R3
      sda_o         <= 1'b0;
      scl_oe_o      <= 1'b0;
      scl_o         <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  pins_low_only_a: assert property (!sda_o && !scl_o && !scl_oe_o) // R3
    else $error("bus pin driven high or clock driven");
  stop_to_idle_a: assert property (stop_det |=> state == scb_pkg::ST_IDLE ##0 !sda_oe_o) // R4
    else $error("stop did not return to idle");
  start_to_addr_a: assert property (start_det |=> state == scb_pkg::ST_ADDR && cnt == 4'h0) // R5
    else $error("start did not open address phase");
  addr_ack_a: assert property (scl_fall && state == scb_pkg::ST_ADDR && byte_done && addr_match
    |=> sda_oe_o && state == scb_pkg::ST_ADDR_ACK) // R6
    else $error("matching address not acknowledged");
  addr_nack_a: assert property (scl_fall && state == scb_pkg::ST_ADDR && byte_done && !addr_match
    |=> !sda_oe_o && state == scb_pkg::ST_IDLE) // R6
    else $error("foreign address acknowledged");
  write_ack_a: assert property (scl_fall && state == scb_pkg::ST_WR_BYTE && byte_done
    |=> sda_oe_o ##1 sda_oe_o [*1]) // R7
    else $error("write byte not acknowledged");
  read_nack_a: assert property (scl_rise && state == scb_pkg::ST_RD_ACK && in_s.pins.sda
    |=> state == scb_pkg::ST_IDLE && $stable(ptr)) // R8
    else $error("read continued after master nack");
  strap_map_a: assert property ($rose(strap_taken) |-> strap_addr == scb_pkg::STRAP_ADDR[
    $past(strap_level)]) // R2
    else $error("strap address does not match level");
  override_a: assert property (scl_fall && state == scb_pkg::ST_ADDR && byte_done && override // R9
    && rx[7:1] == addr_reg[7:1] |=> sda_oe_o && state == scb_pkg::ST_ADDR_ACK)
    else $error("override address not used");
  power_down_a: assert property (auto_pd_en && !in_s.link_up ##1 auto_pd_en |-> power_down_o) // R10
    else $error("power down missing without link");
  full_reset_a: assert property (full_rst |=> addr_reg == scb_pkg::ADDR_REG_RESET && logic_reset_o) // R11
    else $error("full soft reset failed");
  logic_reset_a: assert property (logic_rst && !full_rst |=> logic_reset_o && $stable(addr_reg)
    ##(scb_pkg::SOFT_RST_CYCLES) !logic_reset_o) // R12
    else $error("logic soft reset pulse wrong");
  ptr_advance_a: assert property (wr_strobe |=> ptr == $past(ptr_next_byte)) // R13
    else $error("pointer did not advance");

  write_seen_c: cover property (wr_strobe);
  read_more_c: cover property (state == scb_pkg::ST_RD_ACK && scl_fall);
  restart_c: cover property (state == scb_pkg::ST_WR_ACK ##[1:400] start_det);
  override_c: cover property ($rose(override));

endmodule // scb_serial_control_bus_slave

// ===== scb_strap_decode.sv
`timescale 1ns/1ns
module scb_strap_decode (
  input  wire logic [7:0] level_i,
  output logic      [3:0] level_o,
  output logic      [6:0] addr_o
);

  // comparator bank gives a thermometer code; count ones so one bad bit moves one step only
  function automatic logic [3:0] count_ones(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  assign level_o = count_ones(level_i);                // R1
  assign addr_o  = scb_pkg::STRAP_ADDR[level_o];       // R2

endmodule // scb_strap_decode

// ===== scb_sync.sv
`timescale 1ns/1ns
module scb_sync #(
  parameter int WIDTH = 11
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  // first stage feeds the second stage only
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule // scb_sync

// ===== tb.sv
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic       is_ack;
    logic [7:0] data;
  } scb_note_t;

  logic       ref_clk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic [7:0] strap = 8'h00;
  logic       link = 1'b1;
  logic       scl_oe_o, sda_oe_o, scl_o, sda_o, power_down_o, logic_reset_o;
  logic       h_scl_oe, h_sda_oe, res_valid, res_is_ack;
  logic [7:0] res_data, rv;
  logic [6:0] a;
  wire        scl_line = ~(h_scl_oe | scl_oe_o);
  wire        sda_line = ~(h_sda_oe | sda_oe_o);
  scb_note_t  notes[$];
  scb_note_t  n;
  int         miscompares = 0, samples_checked = 0, cycles = 0, rst_run = 0, rst_len = 0;

  always #20 ref_clk_i = ~ref_clk_i;

  scb_serial_control_bus_slave scb_serial_control_bus_slave_inst (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .scl_i(scl_line), .sda_i(sda_line),
    .address_strap_pin_i(strap), .link_detected_i(link), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .power_down_o(power_down_o), .logic_reset_o(logic_reset_o));

  scb_host_model scb_host_model_inst (
    .ref_clk_i(ref_clk_i), .sda_i(sda_line), .scl_oe_o(h_scl_oe), .sda_oe_o(h_sda_oe),
    .res_valid_o(res_valid), .res_is_ack_o(res_is_ack), .res_data_o(res_data));

  task automatic bad(input string m);
    miscompares++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic compare_ack(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) bad("ack bit differs");
  endtask
  task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) bad("byte differs");
  endtask
  task automatic compare_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) bad("flag differs");
  endtask

  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // results come back in order, so the oldest note always belongs to the newest result
  always @(posedge ref_clk_i) begin
    cycles++;
    if (rstn_i) compare_flag(scl_oe_o | scl_o | sda_o, 1'b0);
    if (logic_reset_o === 1'b1) rst_run++;
    else if (rst_run != 0) begin
      rst_len = rst_run;
      rst_run = 0;
    end
    if (res_valid === 1'b1) begin
      if (notes.size() == 0) bad("result without note");
      else begin
        n = notes.pop_front();
        compare_flag(res_is_ack, n.is_ack);
        if (n.is_ack) compare_ack(res_data[0], n.data[0]);
        else compare_byte(res_data, n.data);
      end
    end
    if (cycles == 90000) begin
      bad("timeout");
      final_report();
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic do_reset(input int lvl);
    strap = 8'(8'hff >> (8 - lvl));
    rstn_i = 1'b0;
    tick(5);
    rstn_i = 1'b1;
    tick(8);
  endtask
  task automatic send(input logic [7:0] d, input logic ack);
    notes.push_back({1'b1, 7'h00, ack});
    scb_host_model_inst.send_byte(d);
  endtask
  task automatic addr_only(input logic [6:0] ad, input logic ack);
    scb_host_model_inst.start_cond();
    send({ad, 1'b0}, ack);
    scb_host_model_inst.stop_cond();
  endtask
  task automatic wr_reg(input logic [6:0] ad, input logic [7:0] ofs, input logic [7:0] d);
    rst_len = 0;
    scb_host_model_inst.start_cond();
    send({ad, 1'b0}, 1'b1);
    send(ofs, 1'b1);
    send(d, 1'b1);
    scb_host_model_inst.stop_cond();
  endtask
  task automatic rd2(input logic [6:0] ad, input logic [7:0] ofs, input logic [7:0] e0,
                     input logic [7:0] e1);
    scb_host_model_inst.start_cond();
    send({ad, 1'b0}, 1'b1);
    send(ofs, 1'b1);
    scb_host_model_inst.start_cond();
    send({ad, 1'b1}, 1'b1);
    notes.push_back({1'b0, e0});
    scb_host_model_inst.recv_byte(1'b1);
    notes.push_back({1'b0, e1});
    scb_host_model_inst.recv_byte(1'b0);
    scb_host_model_inst.stop_cond();
  endtask

  initial begin
    void'($urandom(32'h7ca3656a));
    for (int lvl = 0; lvl < scb_pkg::STRAP_LEVELS; lvl++) begin
      do_reset(lvl);
      addr_only(scb_pkg::STRAP_ADDR[lvl], 1'b1);
      addr_only(scb_pkg::STRAP_ADDR[lvl] ^ 7'h40, 1'b0);
    end
    a = scb_pkg::STRAP_ADDR[8];
    link = 1'b0;
    wr_reg(a, scb_pkg::RST_REG_OFS, 8'h80);
    tick(6);
    compare_flag(power_down_o, 1'b1);
    link = 1'b1;
    tick(6);
    compare_flag(power_down_o, 1'b0);
    rd2(a, scb_pkg::RST_REG_OFS, 8'h80, scb_pkg::UNMAPPED_READ);
    rv = 8'($urandom()) & 8'hfe;
    scb_host_model_inst.start_cond();
    send({a, 1'b0}, 1'b1);
    send(scb_pkg::ADDR_REG_OFS, 1'b1);
    send(rv, 1'b1);
    send(8'h00, 1'b1);
    scb_host_model_inst.stop_cond();
    rd2(a, scb_pkg::ADDR_REG_OFS, rv, 8'h00);
    wr_reg(a, scb_pkg::ADDR_REG_OFS, 8'hab);
    addr_only(a, 1'b0);
    addr_only(7'h55, 1'b1);
    scb_host_model_inst.q = 40;
    wr_reg(7'h55, scb_pkg::RST_REG_OFS, 8'h81);
    compare_byte(8'(rst_len), 8'(scb_pkg::SOFT_RST_CYCLES));
    rd2(7'h55, scb_pkg::ADDR_REG_OFS, 8'hab, 8'h80);
    scb_host_model_inst.q = 16;
    wr_reg(7'h55, scb_pkg::RST_REG_OFS, 8'h02);
    compare_byte(8'(rst_len), 8'(scb_pkg::SOFT_RST_CYCLES));
    rd2(a, scb_pkg::ADDR_REG_OFS, scb_pkg::ADDR_REG_RESET, scb_pkg::RST_REG_RESET);
    tick(4);
    compare_byte(8'(notes.size()), 8'h00);
    final_report();
  end
endmodule // tb
